// ==== pkg/ekami_pkg.sv ====
// constants shared by the external, key and address-match interrupt block
package ekami_pkg;
    localparam int EXT_N = 4;
    localparam int KEY_N = 4;
    localparam int MATCH_N = 4;
    localparam int MASK_N = 5;
    localparam int FLAG_N = 9;
    localparam int LVL_W = 3;
    localparam int NUM_W = 4;
    localparam int SYNC_N = 2;
    localparam int KEY_FLAG = 4;
    localparam int MATCH_FLAG0 = 5;
    localparam int RET_SHORT = 2;
    localparam int RET_LONG = 1;
    localparam logic [7:0] OFF_VEC = 8'h00;
    localparam logic [7:0] OFF_POL = 8'h04;
    localparam logic [7:0] OFF_KDIR = 8'h08;
    localparam logic [7:0] OFF_MEN_A = 8'h0C;
    localparam logic [7:0] OFF_MEN_B = 8'h10;
    localparam logic [7:0] OFF_LVL = 8'h14;
    localparam logic [7:0] OFF_FLAGS = 8'h18;
    localparam logic [7:0] OFF_CFG = 8'h1C;
    localparam logic [3:0] OFF_RMAD_HI = 4'h2;
    localparam logic [3:0] RST_POL = 4'h0;
    localparam logic [3:0] RST_KDIR = 4'h0;
    localparam logic [1:0] RST_MEN = 2'h0;
    localparam logic [14:0] RST_LVL = 15'h0000;
    localparam logic [8:0] RST_FLAGS = 9'h000;
    localparam logic RST_BUS8 = 1'b0;
    localparam logic [3:0] RST_EDGE_PREV = 4'hF;
    localparam logic RST_KEY_PREV = 1'b1;
endpackage

// ==== pkg/ekami_evt_if.sv ====
// event carrier between pin detector, match units and the top
`timescale 1ns/10ps
interface ekami_evt_if #(
    parameter int ADDR_W = 20
);
    logic [ekami_pkg::EXT_N-1:0] ext_evt;
    logic key_evt;
    logic key_low;
    logic [ekami_pkg::MATCH_N-1:0] match_evt;
    logic [ekami_pkg::MATCH_N-1:0][ADDR_W-1:0] match_ret;
    modport det (
        output ext_evt,
        output key_evt,
        output key_low
    );
    modport mu (
        output match_evt,
        output match_ret
    );
    modport sink (
        input ext_evt,
        input key_evt,
        input key_low,
        input match_evt,
        input match_ret
    );
endinterface

// ==== rtl/ekami_pin_det.sv ====
// synchronisers and edge/level detection for external and key pins
`timescale 1ns/10ps
module ekami_pin_det (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [ekami_pkg::EXT_N-1:0] ext_pins,
    input wire logic [ekami_pkg::KEY_N-1:0] key_pins,
    input wire logic [ekami_pkg::EXT_N-1:0] pol,
    input wire logic [ekami_pkg::KEY_N-1:0] kdir,
    ekami_evt_if.det ev
);
    localparam int PIN_N = ekami_pkg::EXT_N + ekami_pkg::KEY_N;
    logic [PIN_N-1:0] s1_q, s1_d, s2_q, s2_d;
    logic [ekami_pkg::EXT_N-1:0] prev_q, prev_d, act;
    logic key_prev_q, key_prev_d, klow;

    always_comb begin
        s1_d = {key_pins, ext_pins};
        s2_d = s1_q;
        // polarity change flips act and can fake an edge
        act = ~(s2_q[ekami_pkg::EXT_N-1:0] ^ pol);
        prev_d = act;
        ev.ext_evt = act & ~prev_q;
        // one aggregate level masks later falls while any pin is held low
        klow = |(~s2_q[PIN_N-1:ekami_pkg::EXT_N] & ~kdir);
        key_prev_d = klow;
        ev.key_evt = klow & ~key_prev_q;
        ev.key_low = klow;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            prev_q <= ekami_pkg::RST_EDGE_PREV;
            key_prev_q <= ekami_pkg::RST_KEY_PREV;
        end else if (ce) begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            prev_q <= prev_d;
            key_prev_q <= key_prev_d;
        end
    end
endmodule

// ==== rtl/ekami_match_unit.sv ====
// address compare units and their stacked return values
`timescale 1ns/10ps
module ekami_match_unit #(
    parameter int ADDR_W = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic fetch_valid,
    input wire logic fetch_short,
    input wire logic fetch_ext,
    input wire logic bus8,
    input wire logic [ekami_pkg::MATCH_N-1:0] en,
    input wire logic [ekami_pkg::MATCH_N-1:0][ADDR_W-1:0] cmp,
    ekami_evt_if.mu ev
);
    logic [ekami_pkg::MATCH_N-1:0][ADDR_W-1:0] ret_q, ret_d;
    logic [ADDR_W-1:0] ret_val;
    logic blocked;

    always_comb begin
        // external area on an 8-bit bus cannot be watched
        blocked = fetch_ext & bus8;
        ret_val = fetch_short ? fetch_addr + ADDR_W'(ekami_pkg::RET_SHORT)
                              : fetch_addr + ADDR_W'(ekami_pkg::RET_LONG);
        ret_d = ret_q;
        for (int i = 0; i < ekami_pkg::MATCH_N; i++) begin
            ev.match_evt[i] = fetch_valid & en[i] & ~blocked
                              & (fetch_addr == cmp[i]);
            if (ev.match_evt[i]) begin
                ret_d[i] = ret_val;
            end
        end
        // next value, so a hit's return word is ready in its own cycle
        ev.match_ret = ret_d;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ret_q <= '0;
        end else if (ce) begin
            ret_q <= ret_d;
        end
    end
endmodule

// ==== rtl/ekami_top.sv ====
// external, key-input and address-match interrupt sources with request flags
// Function
// - each external input requests on the edge its polarity bit selects
// - any input-configured key pin driven low raises a key request
// - a key request wakes the part from wait or stop
// - while one key pin is low, falls on other key pins go unseen
// - a match unit requests just before its compare address executes
// - two bits of each enable register gate the four match units
// - match requests ignore the global enable flag and processor level
// - stacked value is compare address plus two for short forms, else one
// - no address match on external areas with an eight-bit bus
// - reading the vector address clears the top enabled pending flag
// - polarity change may set the flag; software then clears it
// - bit instructions on control registers may lose a racing request
// - accepting reads number and level from vector address, clears flag
// - maskable accept needs global enable, flag set, level above processor
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module ekami_top #(
    parameter int ADDR_W = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [ekami_pkg::EXT_N-1:0] ext_irq_input,
    input wire logic [ekami_pkg::KEY_N-1:0] key_pins,
    input wire logic cpu_i_flag,
    input wire logic [ekami_pkg::LVL_W-1:0] processor_priority_level,
    input wire logic [ADDR_W-1:0] cpu_fetch_addr,
    input wire logic cpu_fetch_valid,
    input wire logic cpu_fetch_short,
    input wire logic cpu_fetch_ext,
    input wire logic cpu_match_ack,
    input wire logic cpu_sleep,
    output logic irq_req,
    output logic [ekami_pkg::NUM_W-1:0] irq_num,
    output logic [ekami_pkg::LVL_W-1:0] irq_level,
    output logic match_req,
    output logic [1:0] match_num,
    output logic [ADDR_W-1:0] match_ret,
    output logic wakeup
);
    localparam int MN = ekami_pkg::MATCH_N;
    localparam int LW = ekami_pkg::LVL_W;

    initial begin
        if (ADDR_W < 2 || ADDR_W > 32) begin
            $error("ekami_top: ADDR_W must lie in 2..32");
        end
        // the packing below is fixed to these package figures
        if (ekami_pkg::EXT_N != 4 || ekami_pkg::KEY_N != 4) begin
            $error("ekami_top: pin groups must be four wide");
        end
        if (ekami_pkg::MATCH_N != 4) begin
            $error("ekami_top: two enable pairs serve four units");
        end
        if (ekami_pkg::MASK_N != ekami_pkg::EXT_N + 1) begin
            $error("ekami_top: maskable sources are pins and key");
        end
        if (ekami_pkg::FLAG_N != ekami_pkg::MASK_N + ekami_pkg::MATCH_N) begin
            $error("ekami_top: one flag per source");
        end
        if (ekami_pkg::MASK_N * LW != 15) begin
            $error("ekami_top: level word is 15 bits");
        end
        if (LW + ekami_pkg::NUM_W != 7) begin
            $error("ekami_top: vector word packs 7 bits");
        end
        if ((1 << ekami_pkg::NUM_W) < ekami_pkg::MASK_N) begin
            $error("ekami_top: source number too narrow");
        end
        if (ekami_pkg::KEY_FLAG != ekami_pkg::EXT_N) begin
            $error("ekami_top: key flag follows pin flags");
        end
        if (ekami_pkg::MATCH_FLAG0 != ekami_pkg::KEY_FLAG + 1) begin
            $error("ekami_top: match flags follow key flag");
        end
        if (ekami_pkg::SYNC_N != 2) begin
            $error("ekami_top: detector has two sync stages");
        end
        if (ekami_pkg::OFF_CFG[7:4] >= ekami_pkg::OFF_RMAD_HI) begin
            $error("ekami_top: map overlaps compare words");
        end
        if (ekami_pkg::RST_EDGE_PREV != 4'hF || !ekami_pkg::RST_KEY_PREV) begin
            $error("ekami_top: edge history must reset high");
        end
        if (ekami_pkg::RET_SHORT != ekami_pkg::RET_LONG + 1) begin
            $error("ekami_top: short forms stack one more");
        end
    end

    typedef struct packed {
        logic valid;
        logic [ekami_pkg::NUM_W-1:0] num;
        logic [LW-1:0] lvl;
    } ekami_pick_t;

    // per-source level field out of the packed level register
    function automatic logic [LW-1:0] lvl_of(input logic [14:0] lv, input int i);
        lvl_of = lv[i*LW +: LW];
    endfunction

    // highest level wins, ties go to the lower source number
    function automatic ekami_pick_t pick_best(input logic [8:0] fl, input logic [14:0] lv);
        ekami_pick_t p;
        logic [LW-1:0] l;
        p = '0;
        l = '0;
        for (int i = 0; i < ekami_pkg::MASK_N; i++) begin
            l = lvl_of(lv, i);
            if (fl[i] && l != '0 && (!p.valid || l > p.lvl)) begin
                p.valid = 1'b1;
                p.num = ekami_pkg::NUM_W'(i);
                p.lvl = l;
            end
        end
        return p;
    endfunction

    // match words sit at 0x20..0x2C
    function automatic logic is_rmad(input logic [7:0] a);
        is_rmad = (a[7:4] == ekami_pkg::OFF_RMAD_HI) && (a[1:0] == 2'h0);
    endfunction

    logic [ekami_pkg::EXT_N-1:0] pol_q, pol_d;
    logic [ekami_pkg::KEY_N-1:0] kdir_q, kdir_d;
    logic [1:0] men_a_q, men_a_d, men_b_q, men_b_d;
    logic [14:0] lvl_q, lvl_d;
    logic [8:0] flag_q, flag_d, evt_set;
    logic bus8_q, bus8_d;
    logic [MN-1:0][ADDR_W-1:0] rmad_q, rmad_d;
    logic [31:0] rdata_q, rdata_d;
    logic irq_req_q, irq_req_d;
    logic [ekami_pkg::NUM_W-1:0] irq_num_q, irq_num_d;
    logic [LW-1:0] irq_lvl_q, irq_lvl_d;
    logic match_req_q, match_req_d;
    logic [1:0] match_num_q, match_num_d;
    logic [ADDR_W-1:0] match_ret_q, match_ret_d;
    logic wake_q, wake_d;
    ekami_pick_t cur_pick, nxt_pick;
    logic vec_rd;

    ekami_evt_if #(.ADDR_W(ADDR_W)) ev ();

    ekami_pin_det u_pin_det (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .ext_pins(ext_irq_input),
        .key_pins(key_pins),
        .pol(pol_q),
        .kdir(kdir_q),
        .ev(ev.det)
    );

    ekami_match_unit #(.ADDR_W(ADDR_W)) u_match (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .fetch_addr(cpu_fetch_addr),
        .fetch_valid(cpu_fetch_valid),
        .fetch_short(cpu_fetch_short),
        .fetch_ext(cpu_fetch_ext),
        .bus8(bus8_q),
        .en({men_b_q, men_a_q}),
        .cmp(rmad_q),
        .ev(ev.mu)
    );

    always_comb begin
        pol_d = pol_q;
        kdir_d = kdir_q;
        men_a_d = men_a_q;
        men_b_d = men_b_q;
        lvl_d = lvl_q;
        bus8_d = bus8_q;
        rmad_d = rmad_q;
        rdata_d = '0;
        cur_pick = pick_best(flag_q, lvl_q);
        vec_rd = reg_rd && (reg_addr == ekami_pkg::OFF_VEC);

        // configuration writes
        if (reg_wr) begin
            unique case (reg_addr)
                ekami_pkg::OFF_POL: begin
                    pol_d = reg_wdata[ekami_pkg::EXT_N-1:0];
                end
                ekami_pkg::OFF_KDIR: begin
                    kdir_d = reg_wdata[ekami_pkg::KEY_N-1:0];
                end
                ekami_pkg::OFF_MEN_A: begin
                    men_a_d = reg_wdata[1:0];
                end
                ekami_pkg::OFF_MEN_B: begin
                    men_b_d = reg_wdata[1:0];
                end
                ekami_pkg::OFF_LVL: begin
                    lvl_d = reg_wdata[14:0];
                end
                ekami_pkg::OFF_CFG: begin
                    bus8_d = reg_wdata[0];
                end
                default: begin
                    if (is_rmad(reg_addr)) begin
                        rmad_d[reg_addr[3:2]] = reg_wdata[ADDR_W-1:0];
                    end
                end
            endcase
        end

        // request flags: software may only clear, by writing zero
        flag_d = flag_q;
        if (reg_wr && reg_addr == ekami_pkg::OFF_FLAGS) begin
            flag_d = flag_q & reg_wdata[8:0];
        end
        if (vec_rd && cur_pick.valid) begin
            flag_d[cur_pick.num] = 1'b0;
        end
        if (cpu_match_ack && match_req_q) begin
            flag_d[ekami_pkg::MATCH_FLAG0 + int'(match_num_q)] = 1'b0;
        end
        // set beats clear so a racing event is kept
        evt_set = {ev.match_evt, ev.key_evt, ev.ext_evt};
        flag_d = flag_d | evt_set;

        // read data, valid only in the cycle after the strobe
        if (reg_rd) begin
            unique case (reg_addr)
                ekami_pkg::OFF_VEC: begin
                    rdata_d = {24'h000000, cur_pick.valid, cur_pick.lvl, cur_pick.num};
                end
                ekami_pkg::OFF_POL: begin
                    rdata_d = {28'h0000000, pol_q};
                end
                ekami_pkg::OFF_KDIR: begin
                    rdata_d = {28'h0000000, kdir_q};
                end
                ekami_pkg::OFF_MEN_A: begin
                    rdata_d = {30'h00000000, men_a_q};
                end
                ekami_pkg::OFF_MEN_B: begin
                    rdata_d = {30'h00000000, men_b_q};
                end
                ekami_pkg::OFF_LVL: begin
                    rdata_d = {17'h00000, lvl_q};
                end
                ekami_pkg::OFF_FLAGS: begin
                    rdata_d = {23'h000000, flag_q};
                end
                ekami_pkg::OFF_CFG: begin
                    rdata_d = {30'h00000000, ev.key_low, bus8_q};
                end
                default: begin
                    if (is_rmad(reg_addr)) begin
                        rdata_d = 32'(rmad_q[reg_addr[3:2]]);
                    end
                end
            endcase
        end

        // cpu side is computed from the next flags to avoid a stale cycle
        nxt_pick = pick_best(flag_d, lvl_d);
        irq_req_d = nxt_pick.valid && cpu_i_flag
                    && (nxt_pick.lvl > processor_priority_level);
        irq_num_d = nxt_pick.num;
        irq_lvl_d = nxt_pick.lvl;

        // match requests bypass the enable flag and level
        match_req_d = 1'b0;
        match_num_d = match_num_q;
        match_ret_d = match_ret_q;
        for (int i = MN - 1; i >= 0; i--) begin
            if (flag_d[ekami_pkg::MATCH_FLAG0 + i]) begin
                match_req_d = 1'b1;
                match_num_d = 2'(i);
                match_ret_d = ev.match_ret[i];
            end
        end
        // a fresh hit's word comes from the unit's next value

        // key request held while asleep pulls the core out
        wake_d = cpu_sleep && flag_d[ekami_pkg::KEY_FLAG];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pol_q <= ekami_pkg::RST_POL;
            kdir_q <= ekami_pkg::RST_KDIR;
            men_a_q <= ekami_pkg::RST_MEN;
            men_b_q <= ekami_pkg::RST_MEN;
            lvl_q <= ekami_pkg::RST_LVL;
            flag_q <= ekami_pkg::RST_FLAGS;
            bus8_q <= ekami_pkg::RST_BUS8;
            rmad_q <= '0;
            rdata_q <= '0;
            irq_req_q <= 1'b0;
            irq_num_q <= '0;
            irq_lvl_q <= '0;
            match_req_q <= 1'b0;
            match_num_q <= '0;
            match_ret_q <= '0;
            wake_q <= 1'b0;
        end else if (ce) begin
            pol_q <= pol_d;
            kdir_q <= kdir_d;
            men_a_q <= men_a_d;
            men_b_q <= men_b_d;
            lvl_q <= lvl_d;
            flag_q <= flag_d;
            bus8_q <= bus8_d;
            rmad_q <= rmad_d;
            rdata_q <= rdata_d;
            irq_req_q <= irq_req_d;
            irq_num_q <= irq_num_d;
            irq_lvl_q <= irq_lvl_d;
            match_req_q <= match_req_d;
            match_num_q <= match_num_d;
            match_ret_q <= match_ret_d;
            wake_q <= wake_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq_req = irq_req_q;
    assign irq_num = irq_num_q;
    assign irq_level = irq_lvl_q;
    assign match_req = match_req_q;
    assign match_num = match_num_q;
    assign match_ret = match_ret_q;
    assign wakeup = wake_q;
endmodule

// ==== testbench/ekami_top_props.sv ====
// port-level assertions for the interrupt source block
`timescale 1ns/10ps
module ekami_top_props #(
    parameter int ADDR_W = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic cpu_i_flag,
    input wire logic [ekami_pkg::LVL_W-1:0] processor_priority_level,
    input wire logic [ADDR_W-1:0] cpu_fetch_addr,
    input wire logic cpu_fetch_valid,
    input wire logic cpu_fetch_short,
    input wire logic cpu_fetch_ext,
    input wire logic cpu_match_ack,
    input wire logic cpu_sleep,
    input wire logic irq_req,
    input wire logic [ekami_pkg::NUM_W-1:0] irq_num,
    input wire logic [ekami_pkg::LVL_W-1:0] irq_level,
    input wire logic match_req,
    input wire logic [ADDR_W-1:0] match_ret,
    input wire logic wakeup
);
    logic bus8_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // shadow of the bus width bit, updated on the same edge as the design
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus8_q <= 1'b0;
        end else if (reg_wr && reg_addr == ekami_pkg::OFF_CFG) begin
            bus8_q <= reg_wdata[0];
        end
    end
    property p_vec;
        reg_rd && reg_addr == ekami_pkg::OFF_VEC && irq_req
        |=> reg_rdata == {24'h0, 1'b1, $past(irq_level), $past(irq_num)};
    endproperty
    a_vec: assert property (p_vec) else $error("vector word differs from request");
    property p_gate;
        irq_req |-> $past(cpu_i_flag) && irq_level > $past(processor_priority_level);
    endproperty
    a_gate: assert property (p_gate) else $error("request shown while masked");
    property p_irq_hold;
        irq_req && !reg_rd && !reg_wr && cpu_i_flag && $stable(processor_priority_level)
        |=> irq_req;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("pending request vanished");
    property p_wake;
        wakeup |-> $past(cpu_sleep);
    endproperty
    a_wake: assert property (p_wake) else $error("wakeup while not asleep");
    property p_src;
        $rose(match_req) |-> $past(cpu_fetch_valid);
    endproperty
    a_src: assert property (p_src) else $error("match request without fetch");
    property p_ret;
        $rose(match_req) && !cpu_match_ack
        |=> match_ret == $past(cpu_fetch_addr, 2) + ADDR_W'($past(cpu_fetch_short, 2)) + 1;
    endproperty
    a_ret: assert property (p_ret) else $error("stacked value wrong");
    property p_no8;
        cpu_fetch_valid && cpu_fetch_ext && bus8_q && !match_req |=> !match_req;
    endproperty
    a_no8: assert property (p_no8) else $error("match on external area, 8-bit bus");
    property p_mhold;
        match_req && !cpu_match_ack && !reg_wr |=> match_req;
    endproperty
    a_mhold: assert property (p_mhold) else $error("match request dropped unacked");
    c_vec: cover property (reg_rd && reg_addr == ekami_pkg::OFF_VEC && irq_req);
    c_match: cover property ($rose(match_req));
    c_wake: cover property (wakeup);
endmodule

bind ekami_top ekami_top_props #(.ADDR_W(ADDR_W)) u_props (.sys_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_i_flag, .processor_priority_level,
    .cpu_fetch_addr, .cpu_fetch_valid, .cpu_fetch_short, .cpu_fetch_ext, .cpu_match_ack,
    .cpu_sleep, .irq_req, .irq_num, .irq_level, .match_req, .match_ret, .wakeup);

// ==== testbench/ekami_cpu_model.sv ====
// core-side model: takes a presented match request after a set delay
`timescale 1ns/10ps
module ekami_cpu_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] dly,
    input wire logic match_req,
    input wire logic [1:0] match_num,
    input wire logic [19:0] match_ret,
    output logic cpu_match_ack,
    output logic [1:0] got_num,
    output logic [19:0] got_ret,
    output logic [7:0] n_ack
);
    logic [3:0] cnt_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            cpu_match_ack <= 1'b0;
            got_num <= 2'h0;
            got_ret <= 20'h0;
            n_ack <= 8'h0;
        end else begin
            cpu_match_ack <= 1'b0;
            cnt_q <= 4'h0;
            if (match_req && !cpu_match_ack && cnt_q < dly) begin
                cnt_q <= cnt_q + 4'h1;
            end
            // acceptance ignores the global flag and level
            if (match_req && !cpu_match_ack && cnt_q >= dly) begin
                cpu_match_ack <= 1'b1;
            end
            // the value to stack is taken with the acknowledge
            if (cpu_match_ack) begin
                got_num <= match_num;
                got_ret <= match_ret;
                n_ack <= n_ack + 8'h1;
            end
        end
    end
endmodule

// ==== testbench/ekami_top_bench.sv ====
// self-checking bench for the interrupt source block
`timescale 1ns/10ps
module ekami_top_bench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] ext = 4'hF;
    logic [3:0] key_pins = 4'hF;
    logic ce = 1'b1;
    logic i_flag = 1'b1;
    logic [2:0] ppl = 3'h0;
    logic [19:0] f_addr = 20'h0;
    logic f_valid = 1'b0;
    logic f_short = 1'b0;
    logic f_ext = 1'b0;
    logic sleep = 1'b0;
    logic [3:0] dly = 4'h1;
    logic [31:0] reg_rdata;
    logic irq_req, match_req, wakeup, cpu_match_ack;
    logic [3:0] irq_num;
    logic [2:0] irq_level;
    logic [1:0] match_num, got_num;
    logic [19:0] match_ret, got_ret;
    logic [7:0] n_ack;
    logic [7:0] offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h30};
    int n_fail = 0;
    int check_count = 0;

    ekami_top #(.ADDR_W(20)) uut (.sys_clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .ext_irq_input(ext), .key_pins, .cpu_i_flag(i_flag),
        .processor_priority_level(ppl), .cpu_fetch_addr(f_addr), .cpu_fetch_valid(f_valid),
        .cpu_fetch_short(f_short), .cpu_fetch_ext(f_ext), .cpu_match_ack,
        .cpu_sleep(sleep), .irq_req, .irq_num, .irq_level, .match_req, .match_num,
        .match_ret, .wakeup);
    ekami_cpu_model cpu (.sys_clk, .rst, .dly, .match_req, .match_num, .match_ret,
        .cpu_match_ack, .got_num, .got_ret, .n_ack);

    always #2 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // pins pass two sync stages, so give them five edges
    task automatic pins(input logic [3:0] e, input logic [3:0] k);
        @(posedge sys_clk);
        ext <= e;
        key_pins <= k;
        repeat (5) @(posedge sys_clk);
        #1;
    endtask
    task automatic setc(input logic f, input logic [2:0] p, input logic s);
        @(posedge sys_clk);
        i_flag <= f;
        ppl <= p;
        sleep <= s;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // a polarity change may raise a fake edge, so clear only after it settles
    task automatic polar(input logic [31:0] v);
        wr(8'h04, v);
        repeat (4) @(posedge sys_clk);
        wr(8'h18, 32'h0);
    endtask
    task automatic fetch(input logic [19:0] a, input logic s, input logic x, input logic hit,
                         input logic [1:0] u);
        logic [7:0] n0;
        n0 = n_ack;
        @(posedge sys_clk);
        f_valid <= 1'b1;
        f_addr <= a;
        f_short <= s;
        f_ext <= x;
        @(posedge sys_clk);
        f_valid <= 1'b0;
        for (int k = 0; k < 40 && n_ack == n0; k++) @(posedge sys_clk);
        #1 chk(n_ack - n0, hit);
        chk(match_req, 1'b0);
        if (hit) chk({got_num, got_ret}, {u, a + (s ? 20'h2 : 20'h1)});
    endtask
    task automatic test_done;
        $display("checks=%0d errors=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #120000;
        n_fail++;
        test_done;
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (offs[j]) rd(offs[j], 32'h0);
        wr(8'h14, 32'h58D1);
        for (int i = 0; i < 4; i++) begin
            pins(~(4'h1 << i), 4'hF);
            chk({irq_req, irq_num, irq_level}, {1'b1, 4'(i), 3'(i + 1)});
            rd(8'h00, 32'h80 | ((i + 1) << 4) | i);
            rd(8'h18, 32'h0);
            pins(4'hF, 4'hF);
            rd(8'h18, 32'h0);
            polar(32'h1 << i);
            pins(~(4'h1 << i), 4'hF);
            rd(8'h18, 32'h0);
            pins(4'hF, 4'hF);
            rd(8'h18, 32'h1 << i);
            polar(32'h0);
        end
        pins(4'h6, 4'hF);
        setc(1'b1, 3'h3, 1'b0);
        chk({irq_req, irq_num}, {1'b1, 4'h3});
        setc(1'b1, 3'h4, 1'b0);
        chk(irq_req, 1'b0);
        setc(1'b0, 3'h0, 1'b0);
        chk(irq_req, 1'b0);
        setc(1'b1, 3'h0, 1'b0);
        rd(8'h00, 32'hC3);
        rd(8'h18, 32'h1);
        rd(8'h00, 32'h90);
        rd(8'h18, 32'h0);
        pins(4'hF, 4'hF);
        wr(8'h08, 32'h2);
        pins(4'hF, 4'hD);
        rd(8'h18, 32'h0);
        pins(4'hF, 4'hC);
        rd(8'h18, 32'h10);
        rd(8'h1C, 32'h2);
        wr(8'h18, 32'h0);
        pins(4'hF, 4'h8);
        rd(8'h18, 32'h0);
        pins(4'hF, 4'hF);
        setc(1'b1, 3'h0, 1'b1);
        pins(4'hF, 4'h7);
        chk(wakeup, 1'b1);
        setc(1'b1, 3'h0, 1'b0);
        chk(wakeup, 1'b0);
        wr(8'h18, 32'h0);
        pins(4'hF, 4'hF);
        @(posedge sys_clk);
        ce <= 1'b0;
        pins(4'hE, 4'hF);
        chk(irq_req, 1'b0);
        @(posedge sys_clk);
        ce <= 1'b1;
        pins(4'hE, 4'hF);
        chk({irq_req, irq_num}, {1'b1, 4'h0});
        rd(8'h00, 32'h90);
        pins(4'hF, 4'hF);
        setc(1'b0, 3'h7, 1'b0);
        wr(8'h0C, 32'h3);
        wr(8'h10, 32'h3);
        for (int i = 0; i < 4; i++) wr(8'(8'h20 + 4 * i), 32'h1A000 + 16 * i);
        for (int i = 0; i < 4; i++) fetch(20'(20'h1A000 + 16 * i), i[0], 1'b0, 1'b1, 2'(i));
        dly <= 4'h9;
        fetch(20'h1A010, 1'b1, 1'b1, 1'b1, 2'h1);
        wr(8'h10, 32'h1);
        fetch(20'h1A030, 1'b0, 1'b0, 1'b0, 2'h3);
        fetch(20'h1A020, 1'b0, 1'b0, 1'b1, 2'h2);
        wr(8'h1C, 32'h1);
        fetch(20'h1A000, 1'b0, 1'b1, 1'b0, 2'h0);
        fetch(20'h1A000, 1'b0, 1'b0, 1'b1, 2'h0);
        fetch(20'h1A004, 1'b0, 1'b0, 1'b0, 2'h0);
        test_done;
    end
endmodule
